// ===== design/adcsc_dev.sv
// Converter end: standby, wake-on-falling-clock conversion, MSB-first readback, calibration request.
// Assumes core_clk is the master clock; link pins are asynchronous and resynchronised here.
`timescale 1ns/1ns
module adcsc_dev
	import adcsc_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Link
	adcsc_if.dev link,
	// Analogue stand-in sampled at conversion start
	input wire logic [adcsc_pkg::RES_BITS-1:0] sample_value,
	// Status
	output logic in_standby,
	output logic cal_busy
);
	import adcsc_pkg::*;

	adcsc_dst_t state_r, state_nxt;
	logic sclk_s1, sclk_s2, sclk_s3;
	logic [1:0] sel_s1, sel_s2, sel_s3;
	logic [12:0] timer_r, hi_cnt_r;
	logic [4:0] fall_cnt_r;
	logic [1:0] settle_r;
	logic [RES_BITS-1:0] samp_r, res_r;
	logic rdo_r, cal_pend_r;
	logic fall, stby_hit, sel_chg, conv_end, cal_end;

	// Link pins pass two flops before any use
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			sclk_s1 <= 1'b1;
			sclk_s2 <= 1'b1;
			sclk_s3 <= 1'b1;
			sel_s1 <= 2'b00;
			sel_s2 <= 2'b00;
			sel_s3 <= 2'b00;
		end
		else
		begin
			sclk_s1 <= link.sclk;
			sclk_s2 <= sclk_s1;
			sclk_s3 <= sclk_s2;
			sel_s1 <= {link.channel_select_hi, link.channel_select_lo};
			sel_s2 <= sel_s1;
			sel_s3 <= sel_s2;
		end
	end

	// Edge and level events on the synchronised pins
	assign fall = sclk_s3 & ~sclk_s2;
	assign sel_chg = sel_s2 != sel_s3;
	assign stby_hit = sclk_s2 && (hi_cnt_r == STBY_CYC - 13'd1);
	assign conv_end = (state_r == D_CONV) && (timer_r == CONV_CYC - 13'd1);
	assign cal_end = (state_r == D_CAL) && (timer_r == CAL_CYC - 13'd1);

	// Time the shift clock spends high decides standby entry
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			hi_cnt_r <= 13'd0;
		else if (!sclk_s2 || stby_hit)
			hi_cnt_r <= 13'd0;
		else
			hi_cnt_r <= hi_cnt_r + 13'd1;
	end

	// Mode sequencing
	always_comb
	begin
		state_nxt = state_r;
		unique case (state_r)
			D_CONV:
				if (stby_hit)
					state_nxt = D_STBY;
				else if (conv_end && settle_r == 2'd0 && !sel_chg)
					state_nxt = D_RDY;
			D_RDY:
				if (sel_chg)
					state_nxt = D_CONV;
				else if (stby_hit)
					state_nxt = D_STBY;
				else if (fall && fall_cnt_r == CAL_GO - 5'd1)
					state_nxt = D_CAL;
			D_STBY:
				if (fall)
					state_nxt = cal_pend_r ? D_CAL : D_CONV;
			D_CAL:
				if (cal_end)
					state_nxt = D_CONV;
		endcase
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			state_r <= D_CONV;
		else
			state_r <= state_nxt;
	end

	// Conversion and calibration timer restarts on every mode change or channel change
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			timer_r <= 13'd0;
		else if (state_nxt != state_r || sel_chg || conv_end)
			timer_r <= 13'd0;
		else
			timer_r <= timer_r + 13'd1;
	end

	// Filter settling after a channel change; other converters are untouched
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			settle_r <= 2'd0;
		else if (sel_chg)
			settle_r <= SETTLE_CONV;
		else if (state_r == D_STBY)
			settle_r <= 2'd0;
		else if (conv_end && settle_r != 2'd0)
			settle_r <= settle_r - 2'd1;
	end

	// Input captured at timer zero, so devices woken by one edge sample together
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			samp_r <= '0;
		else if (state_r == D_CONV && timer_r == 13'd0)
			samp_r <= sample_value;
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			res_r <= '0;
		else if (state_r == D_CONV && state_nxt == D_RDY)
			res_r <= samp_r;
	end

	// Falling edges counted during readback
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			fall_cnt_r <= 5'd0;
		else if (state_r != D_RDY)
			fall_cnt_r <= 5'd0;
		else if (fall && fall_cnt_r != 5'h1f)
			fall_cnt_r <= fall_cnt_r + 5'd1;
	end

	// 25 bits shifted then standby asks for calibration at wake-up
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			cal_pend_r <= 1'b0;
		else if (state_r == D_RDY && fall && fall_cnt_r == CAL_LAST - 5'd1)
			cal_pend_r <= 1'b1;
		else if (state_r == D_CAL)
			cal_pend_r <= 1'b0;
	end

	// Ready/data pin: high outside readback, low when ready, then bits MSB first
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			rdo_r <= 1'b1;
		else if (state_nxt != D_RDY)
			rdo_r <= 1'b1;
		else if (state_r != D_RDY)
			rdo_r <= 1'b0;
		else if (fall)
			rdo_r <= (fall_cnt_r < RES_LAST) ? res_r[5'd23 - fall_cnt_r] : 1'b1;
	end

	assign link.ready_data_out = rdo_r;
	assign in_standby = state_r == D_STBY;
	assign cal_busy = state_r == D_CAL;
endmodule

// ===== design/adcsc_host.sv
// Host end: APB-programmed single conversions over the two-wire link, with result and interrupt.
// Assumes the converter shares core_clk; ready_data_out is asynchronous and resynchronised here.
// Behaviour
// - Park shift clock high before converting
// - Falling shift clock wakes converter, converts
// - Wait for ready low before reading
// - Raise shift clock after read; standby
// - Hold shift clock high between conversions
// - Common master clock for all converters
// - Shared wake edge samples simultaneously
// - Each converter shows its bits in parallel
// - Ready falling edges within skew limit
// - Read only after skew interval elapses
// - Channel toggle holds ready high until settled
// - Unchanged converter keeps converting normally
// - Host triggers self-calibration once stable
// - Each falling edge shifts next bit, MSB first
// - 25 bits before standby request calibration
// - Standby drives ready high, needs clock high
// - First result after standby is valid
`timescale 1ns/1ns
module adcsc_host
	import adcsc_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Interrupt
	output logic irq,
	// Link
	adcsc_if.host link
);
	import adcsc_pkg::*;

	adcsc_hst_t state_r;
	logic rdo_s1, rdo_s2;
	logic [12:0] cnt_r;
	logic [4:0] bit_cnt_r;
	logic [RES_BITS-1:0] shift_r, data_r;
	logic [3:0] ctrl_r;
	logic start_r, cal_want_r, sclk_r, parked_r;
	logic [0:0] int_stat_r, int_mask_r;
	logic [31:0] prdata_r;
	logic wr_acc, sel_ok, done_ev;

	function automatic logic decoded(input logic [11:0] a);
		decoded = a == OFS_CTRL || a == OFS_STATUS || a == OFS_DATA || a == OFS_INT_STAT || a == OFS_INT_MASK;
	endfunction

	// Zero-wait slave; unmapped offsets flag an error
	assign pready = 1'b1;
	assign sel_ok = decoded(paddr);
	assign pslverr = psel && penable && !sel_ok;
	assign wr_acc = psel && penable && pwrite && sel_ok;
	assign prdata = prdata_r;
	assign irq = |(int_stat_r & int_mask_r);

	// Ready/data pin passes two flops
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			rdo_s1 <= 1'b1;
			rdo_s2 <= 1'b1;
		end
		else
		begin
			rdo_s1 <= link.ready_data_out;
			rdo_s2 <= rdo_s1;
		end
	end

	// Read data latched in the setup cycle so it is a flop in the access cycle
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			prdata_r <= 32'h0000_0000;
		else if (psel && !penable && !pwrite)
			unique case (paddr)
				OFS_CTRL: prdata_r <= {28'h000_0000, ctrl_r};
				OFS_STATUS: prdata_r <= {30'h0000_0000, parked_r, state_r != H_PARK};
				OFS_DATA: prdata_r <= {8'h00, data_r};
				OFS_INT_STAT: prdata_r <= {31'h0000_0000, int_stat_r};
				OFS_INT_MASK: prdata_r <= {31'h0000_0000, int_mask_r};
				default: prdata_r <= 32'h0000_0000;
			endcase
	end

	// Control register: channel selects are levels, start and calibrate bits self-clear
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			ctrl_r <= CTRL_RST;
		else if (wr_acc && paddr == OFS_CTRL)
			ctrl_r <= {pwdata[CTRL_SEL_HI], pwdata[CTRL_SEL_LO], 2'b00};
	end

	// Start request held until the parked sequencer takes it
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			start_r <= 1'b0;
			cal_want_r <= 1'b0;
		end
		else if (wr_acc && paddr == OFS_CTRL && (pwdata[CTRL_START] || pwdata[CTRL_CAL]))
		begin
			start_r <= 1'b1;
			cal_want_r <= pwdata[CTRL_CAL];
		end
		else if (state_r == H_PARK && start_r)
			start_r <= 1'b0;
	end

	// Mask register
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			int_mask_r <= INT_MASK_RST;
		else if (wr_acc && paddr == OFS_INT_MASK)
			int_mask_r <= pwdata[INT_DONE];
	end

	// Sticky status; a new event beats a same-cycle write-one-to-clear
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			int_stat_r <= 1'b0;
		else if (done_ev)
			int_stat_r <= 1'b1;
		else if (wr_acc && paddr == OFS_INT_STAT && pwdata[INT_DONE])
			int_stat_r <= 1'b0;
	end

	assign done_ev = state_r == H_LOW && cnt_r == HALF_CYC - 13'd1 && bit_cnt_r == (cal_want_r ? CAL_LAST : RES_LAST) - 5'd1;

	// Link sequencer; shift clock is divided from core_clk, which also feeds the converter
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			state_r <= H_INIT;
			cnt_r <= 13'd0;
			bit_cnt_r <= 5'd0;
			sclk_r <= 1'b1;
			parked_r <= 1'b0;
		end
		else
			unique case (state_r)
				H_INIT:
				begin
					sclk_r <= 1'b1;
					cnt_r <= cnt_r + 13'd1;
					if (cnt_r == PARK_CYC - 13'd1)
					begin
						state_r <= H_PARK;
						parked_r <= 1'b1;
						cnt_r <= 13'd0;
					end
				end
				H_PARK:
					if (start_r)
					begin
						sclk_r <= 1'b0;
						parked_r <= 1'b0;
						bit_cnt_r <= 5'd0;
						state_r <= H_WAIT;
					end
				H_WAIT:
					if (!rdo_s2)
					begin
						cnt_r <= 13'd0;
						state_r <= H_SKEW;
					end
				H_SKEW:
				begin
					cnt_r <= cnt_r + 13'd1;
					if (cnt_r == SKEW_CYC - 13'd1)
					begin
						cnt_r <= 13'd0;
						sclk_r <= 1'b1;
						state_r <= H_HIGH;
					end
				end
				H_HIGH:
				begin
					cnt_r <= cnt_r + 13'd1;
					if (cnt_r == HALF_CYC - 13'd1)
					begin
						cnt_r <= 13'd0;
						sclk_r <= 1'b0;
						state_r <= H_LOW;
					end
				end
				H_LOW:
				begin
					cnt_r <= cnt_r + 13'd1;
					if (cnt_r == HALF_CYC - 13'd1)
					begin
						cnt_r <= 13'd0;
						bit_cnt_r <= bit_cnt_r + 5'd1;
						sclk_r <= 1'b1;
						state_r <= done_ev ? H_INIT : H_HIGH;
					end
				end
				default:
					state_r <= H_INIT;
			endcase
	end

	// Bits sampled late in the low half, MSB first
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			shift_r <= '0;
		else if (state_r == H_LOW && cnt_r == HALF_CYC - 13'd1 && bit_cnt_r < RES_LAST)
			shift_r <= {shift_r[RES_BITS-2:0], rdo_s2};
	end

	// Result published when the last pulse ends
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			data_r <= '0;
		else if (done_ev)
			data_r <= (bit_cnt_r < RES_LAST) ? {shift_r[RES_BITS-2:0], rdo_s2} : shift_r;
	end

	assign link.sclk = sclk_r;
	assign link.channel_select_lo = ctrl_r[CTRL_SEL_LO];
	assign link.channel_select_hi = ctrl_r[CTRL_SEL_HI];
endmodule

// ===== design/adcsc_if.sv
// Two-wire link: shift clock from host, ready/data back from converter, channel selects.
// Assumes one host and one converter; the bench connects exactly one of each.
`timescale 1ns/1ns
interface adcsc_if;
	logic sclk;
	logic ready_data_out;
	logic channel_select_lo;
	logic channel_select_hi;
	modport dev (input sclk, input channel_select_lo, input channel_select_hi, output ready_data_out);
	modport host (output sclk, output channel_select_lo, output channel_select_hi, input ready_data_out);
endinterface

// ===== design/adcsc_pkg.sv
// Shared constants for the standby single-conversion link: widths, timing, host register map.
// Assumes both ends run on the same 250 MHz core_clk, which also serves as converter master clock.
package adcsc_pkg;
	// Clock
	localparam int CLK_NS = 4;
	// Result framing
	localparam int RES_BITS = 24;
	localparam logic [4:0] RES_LAST = 5'd24;
	localparam logic [4:0] CAL_LAST = 5'd25;
	localparam logic [4:0] CAL_GO = 5'd26;
	// Converter timing in ns, then cycles
	localparam int CONV_NS = 16000;
	localparam int CAL_NS = 16000;
	localparam int STBY_NS = 2000;
	localparam logic [12:0] CONV_CYC = 13'((CONV_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [12:0] CAL_CYC = 13'((CAL_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [12:0] STBY_CYC = 13'((STBY_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [1:0] SETTLE_CONV = 2'd3;
	// Host timing in ns, then cycles
	localparam int HALF_NS = 500;
	localparam int SKEW_NS = 400;
	localparam logic [12:0] HALF_CYC = 13'(HALF_NS / CLK_NS);
	localparam logic [12:0] SKEW_CYC = 13'((SKEW_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [12:0] PARK_CYC = 13'(2 * ((STBY_NS + CLK_NS - 1) / CLK_NS));
	// Host register byte offsets
	localparam logic [11:0] OFS_CTRL = 12'h000;
	localparam logic [11:0] OFS_STATUS = 12'h004;
	localparam logic [11:0] OFS_DATA = 12'h008;
	localparam logic [11:0] OFS_INT_STAT = 12'h00c;
	localparam logic [11:0] OFS_INT_MASK = 12'h010;
	// Field positions
	localparam int CTRL_START = 0;
	localparam int CTRL_CAL = 1;
	localparam int CTRL_SEL_LO = 2;
	localparam int CTRL_SEL_HI = 3;
	localparam int STAT_BUSY = 0;
	localparam int STAT_PARKED = 1;
	localparam int INT_DONE = 0;
	// Reset values
	localparam logic [3:0] CTRL_RST = 4'h0;
	localparam logic [0:0] INT_MASK_RST = 1'h0;
	// Device states
	typedef enum logic [1:0] {D_CONV = 2'b00, D_RDY = 2'b01, D_STBY = 2'b10, D_CAL = 2'b11} adcsc_dst_t;
	// Host states
	typedef enum logic [2:0] {H_INIT = 3'b000, H_PARK = 3'b001, H_WAIT = 3'b010, H_SKEW = 3'b011,
		H_HIGH = 3'b100, H_LOW = 3'b101} adcsc_hst_t;
endpackage

// ===== tb/adcsc_asserts.sv
// Link checker: timing of wake, conversion, readback and standby on the wire.
// Assumes one clock for both ends; placed beside the interface, not bound.
`timescale 1ns/1ns
module adcsc_asserts
	import adcsc_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Link
	input wire logic sclk,
	input wire logic ready_data_out,
	input wire logic channel_select_lo,
	input wire logic channel_select_hi,
	// Converter status
	input wire logic in_standby,
	input wire logic cal_busy
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);
	localparam int T_CONV = int'(CONV_CYC);
	localparam int T_CAL = T_CONV + int'(CAL_CYC);
	localparam int T_SEL = T_CONV * (int'(SETTLE_CONV) + 1);
	logic sclk_q, lo_q, hi_q, armed_r, cal_r, sel_r;
	logic [14:0] cnt_r, sc_r, rc_r;
	logic [4:0] falls_r;
	logic [9:0] hi_r;
	wire wake = sclk_q && !sclk && in_standby;
	wire sel_chg = (lo_q != channel_select_lo) || (hi_q != channel_select_hi);
	// Phase flags; armed from wake until the first ready low
	always_ff @(posedge core_clk)
	begin
		sclk_q <= sclk;
		lo_q <= channel_select_lo;
		hi_q <= channel_select_hi;
		armed_r <= !rst_n || wake || (armed_r && ready_data_out);
		cal_r <= rst_n && (wake ? (falls_r == 5'h19) : cal_r);
		sel_r <= rst_n && !wake && (sel_r || (armed_r && sel_chg));
	end
	// Cycle counters; a wrap is harmless within one frame
	always_ff @(posedge core_clk)
	begin
		cnt_r <= (wake || !rst_n) ? 15'h0000 : cnt_r + 15'h0001;
		sc_r <= sel_chg ? 15'h0000 : sc_r + 15'h0001;
		rc_r <= (armed_r && !ready_data_out) ? 15'h0000 : rc_r + 15'h0001;
		hi_r <= !sclk ? 10'h000 : hi_r + {9'h000, hi_r != 10'h3ff};
	end
	// Readback falls, cleared at wake
	always_ff @(posedge core_clk)
	begin
		if (!rst_n || wake)
			falls_r <= 5'h00;
		else if (sclk_q && !sclk && !armed_r && !in_standby)
			falls_r <= falls_r + 5'h01;
	end
	stby_ready_high_a: assert property (in_standby |-> ready_data_out)
		else $error("ready low in standby");
	stby_exit_a: assert property (in_standby && !sclk |-> ##[1:6] !in_standby)
		else $error("no wake after clock fall");
	conv_time_a: assert property (armed_r && !ready_data_out && !cal_r && !sel_r |->
		cnt_r inside {[T_CONV-5:T_CONV+15]}) else $error("conversion time wrong");
	cal_time_a: assert property (armed_r && !ready_data_out && cal_r && !sel_r |->
		cnt_r inside {[T_CAL-5:T_CAL+20]}) else $error("calibrated conversion time wrong");
	sel_settle_a: assert property (armed_r && !ready_data_out && sel_r |->
		sc_r inside {[T_SEL-5:T_SEL+20]}) else $error("settling after select wrong");
	cal_start_a: assert property (wake && falls_r == 5'h19 |-> ##[1:10] cal_busy)
		else $error("calibration not started");
	early_read_a: assert property ($rose(sclk) |-> !armed_r)
		else $error("clock raised before ready");
	skew_wait_a: assert property ($rose(sclk) && falls_r == 5'h00 && !in_standby |-> rc_r >= SKEW_CYC)
		else $error("readback before skew wait");
	park_fall_a: assert property ($fell(sclk) |-> in_standby || hi_r <= 10'h0c8)
		else $error("clock fell outside standby after long high");
	bit_on_fall_a: assert property ($changed(ready_data_out) && !armed_r && !in_standby
		&& !$rose(in_standby) |-> !sclk) else $error("bit changed with clock high");
	cover property (wake);
	cover property (wake && falls_r == 5'h19);
	cover property (armed_r && sel_chg);
endmodule

// ===== tb/adcsc_tb_top.sv
// Bench: host and converter ends joined by the link, host driven over APB.
// Assumes one clock for both ends; results predicted by a queue model.
`timescale 1ns/1ns
module adc_standby_single_conversion_ctrl_tb_top;
	import adcsc_pkg::*;
	logic core_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, err, cal_q = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
	logic pready, pslverr, irq, in_standby, cal_busy;
	logic [RES_BITS-1:0] sample_value = 24'h00_0000;
	logic [RES_BITS-1:0] exp_q[$];
	integer n_mismatch = 0, checked = 0, seed = 32'h0000_0759, cal_rise = 0;
	adcsc_if link_if();
	adcsc_host adcsc_host_inst (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq(irq), .link(link_if.host));
	adcsc_dev adcsc_dev_inst (.core_clk(core_clk), .rst_n(rst_n), .link(link_if.dev),
		.sample_value(sample_value), .in_standby(in_standby), .cal_busy(cal_busy));
	adcsc_asserts adcsc_asserts_inst (.core_clk(core_clk), .rst_n(rst_n), .sclk(link_if.sclk),
		.ready_data_out(link_if.ready_data_out), .channel_select_lo(link_if.channel_select_lo),
		.channel_select_hi(link_if.channel_select_hi), .in_standby(in_standby), .cal_busy(cal_busy));
	// 250 MHz clock
	initial
	begin
		forever #2 core_clk = ~core_clk;
	end
	// Count calibration runs; bench only sees them as status
	always @(posedge core_clk)
	begin
		cal_q <= cal_busy;
		if (cal_busy === 1'b1 && cal_q !== 1'b1)
			cal_rise <= cal_rise + 1;
	end
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// One APB transfer; waits on pready, no fixed latency assumed
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		// Only the watchdog ends a wait that never sees pready
		do
		begin
			@(posedge core_clk);
		end
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wait_parked();
		int n;
		n = 0;
		do
		begin
			apb(1'b0, OFS_STATUS, 32'h0000_0000);
			n++;
		end
		while (rd[STAT_PARKED] !== 1'b1 && n < 12000);
		check("status", rd, 32'h0000_0002);
	endtask
	// One single conversion; mid changes a select while converting
	task automatic conv(input logic [31:0] ctrl, input logic m, input logic mid);
		logic [RES_BITS-1:0] s;
		s = RES_BITS'($random(seed));
		sample_value <= s;
		exp_q.push_back(s);
		apb(1'b1, OFS_INT_MASK, {31'h0000_0000, m});
		apb(1'b1, OFS_CTRL, ctrl);
		if (mid)
		begin
			repeat (2000) @(posedge core_clk);
			apb(1'b1, OFS_CTRL, 32'h0000_0004);
		end
		repeat (20) @(posedge core_clk);
		apb(1'b0, OFS_STATUS, 32'h0000_0000);
		check("busy", rd, 32'h0000_0001);
		wait_parked();
		check("select", link_if.channel_select_lo, mid);
		apb(1'b0, OFS_DATA, 32'h0000_0000);
		check("data", rd, exp_q.pop_front());
		check("mapped err", err, 1'b0);
		apb(1'b0, OFS_INT_STAT, 32'h0000_0000);
		check("done flag", rd, 32'h0000_0001);
		check("irq", irq, m);
		apb(1'b1, OFS_INT_STAT, 32'h0000_0001);
		apb(1'b0, OFS_INT_STAT, 32'h0000_0000);
		check("done clear", rd, 32'h0000_0000);
		check("irq clear", irq, 1'b0);
		check("parked pins", {in_standby, link_if.ready_data_out, link_if.sclk}, 3'h7);
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Hang guard, well past the expected run
	initial
	begin
		#380000;
		n_mismatch++;
		wrap_up();
	end
	initial
	begin
		repeat (20) @(posedge core_clk);
		rst_n <= 1'b1;
		apb(1'b0, OFS_CTRL, 32'h0000_0000);
		check("ctrl reset", rd, {28'h000_0000, CTRL_RST});
		apb(1'b0, OFS_INT_MASK, 32'h0000_0000);
		check("mask reset", rd, {31'h0000_0000, INT_MASK_RST});
		apb(1'b1, 12'h014, 32'hffff_ffff);
		apb(1'b0, 12'h014, 32'h0000_0000);
		check("unmapped data", rd, 32'h0000_0000);
		check("unmapped err", err, 1'b1);
		wait_parked();
		conv(32'h0000_0001, 1'b1, 1'b0);
		conv(32'h0000_0001, 1'b0, 1'b0);
		conv(32'h0000_0003, 1'b1, 1'b0);
		check("no cal yet", cal_rise, 32'h0000_0000);
		conv(32'h0000_0001, 1'b1, 1'b0);
		check("cal ran", cal_rise, 32'h0000_0001);
		conv(32'h0000_0001, 1'b0, 1'b1);
		wrap_up();
	end
endmodule
